// ===== buffer_io_space_decoder.sv
// buffer_io_space_decoder: arbitration, decode and access check for the top 2K data space
// assumes all masters share clk, hold req until their grant pulse, and the target
// returns read data combinationally in the cycle its select stands
// Functional notes
// RULE1: F800 through FFFF is decoded into buffer, descriptor, setup and register targets.
// RULE2: the top 128 bytes FF80 to FFFF go to register selects, never to buffer storage.
// RULE3: the core reaches everything; of the registers, the buffer manager reaches only the ep0 registers.
// RULE4: dma reaches the serial-port data registers FFA0/FFA1 and ep0 registers, descriptors only on update, never setup.
// RULE5: ep0 in config/count sit at FF80/FF81 and out config/count at FF82/FF83.
// RULE6: the 8-byte setup store at FF00 to FF07 is open to core and buffer manager, not dma.
// RULE7: data buffers F800 to FEEF, out ep0 buffer at FEF0 and in ep0 buffer at FEF8 serve all.
// RULE8: out ep1-3 descriptors sit at FF08/FF10/FF18 and in ep1-3 at FF48/FF50/FF58.
// RULE9: usb function address, status, mask and control decode at FFFF, FFFE, FFFD, FFFC.
// RULE10: serial number bytes 0 to 7 decode at FFE8 to FFEF.
// RULE11: dma1 definition/status at FFE0/FFE1 and dma3 definition/status at FFE4/FFE5.
// RULE12: the serial-port group decodes at FFA0 through FFAB.
// RULE13: watchdog at FF93, interrupt vector at FF92, code shadow config at FF90.
// RULE14: holes and refused accesses write nothing and read back zero.
// RULE15: simultaneous requests are served one at a time by fixed priority core, manager, dma.
module buffer_io_space_decoder
  import space_decoder_pkg::*;
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset,
  // microcontroller core
  input  wire logic                    mcu_req,
  input  wire logic                    mcu_we,
  input  wire logic [15:0]             mcu_addr,
  input  wire logic [7:0]              mcu_wdata,
  output logic                         mcu_grant_reg,
  // usb buffer manager
  input  wire logic                    usb_buffer_manager_req,
  input  wire logic                    usb_buffer_manager_we,
  input  wire logic [15:0]             usb_buffer_manager_addr,
  input  wire logic [7:0]              usb_buffer_manager_wdata,
  output logic                         usb_buffer_manager_grant_reg,
  // dma channels
  input  wire logic                    dma_req,
  input  wire logic                    dma_we,
  input  wire logic [15:0]             dma_addr,
  input  wire logic [7:0]              dma_wdata,
  input  wire logic                    dma_desc_update,
  output logic                         dma_grant_reg,
  // target side
  output logic                         tgt_valid_reg,
  output logic                         tgt_we_reg,
  output region_t                      tgt_region_reg,
  output logic [OFFSET_WIDTH-1:0]      tgt_offset_reg,
  output logic [7:0]                   tgt_wdata_reg,
  input  wire logic [7:0]              tgt_rdata,
  // completion
  output logic                         refused_reg,
  output logic [2:0]                   done_reg,
  output logic [7:0]                   rdata_reg
);

  // documented register addresses inside the mapped space
  function automatic logic reg_known(input logic [15:0] a);
    reg_known = (a >= IN_EP0_CONFIG && a <= OUT_EP0_BYTE_COUNT)          // see RULE5
             || a == CODE_SHADOW_CONFIG || a == INTERRUPT_VECTOR
             || a == WATCHDOG_CTRL_STATUS                                // see RULE13
             || a == GPIO_PULLUP_PORT3
             || (a >= UART_RX_DATA && a <= UART_INT_MASK)                // see RULE12
             || a == DMA1_CHANNEL_DEFINITION || a == DMA1_CTRL_STATUS
             || a == DMA3_CHANNEL_DEFINITION || a == DMA3_CTRL_STATUS    // see RULE11
             || (a >= SERIAL_NUMBER_BYTE0 && a <= SERIAL_NUMBER_BYTE7)   // see RULE10
             || (a >= I2C_STATUS && a <= I2C_ADDRESS)
             || (a >= DEVICE_REV_LOW && a <= USB_FUNCTION_ADDRESS);      // see RULE9
  endfunction

  function automatic region_t region_of(input logic [15:0] a);
    if (a < BUFFER_SPACE_BASE)
      region_of = REGION_OUTSIDE;
    else if (a <= BUFFER_SPACE_TOP)
      region_of = REGION_DATA;                                           // see RULE7
    else if (a < IN_EP0_BUF_BASE)
      region_of = REGION_OUT_EP0;
    else if (a < SETUP_BASE)
      region_of = REGION_IN_EP0;
    else if (a <= SETUP_TOP)
      region_of = REGION_SETUP;                                          // see RULE6
    else if ((a >= OUT_EP1_DESC_CONFIG && a <= OUT_DESC_TOP)
          || (a >= IN_EP1_DESC_CONFIG && a <= IN_DESC_TOP))
      region_of = REGION_DESC;                                           // see RULE8
    else if (a >= MAPPED_SPACE_BASE && reg_known(a))
      region_of = REGION_REGS;                                           // see RULE2
    else
      region_of = REGION_HOLE;                                           // see RULE1
  endfunction

  function automatic logic is_ep0_reg(input logic [15:0] a);
    is_ep0_reg = a >= IN_EP0_CONFIG && a <= OUT_EP0_BYTE_COUNT;
  endfunction

  function automatic logic allowed(input master_t m, input region_t r,
                                   input logic [15:0] a, input logic upd);
    allowed = 1'b0;
    if (r == REGION_OUTSIDE || r == REGION_HOLE)
      allowed = 1'b0;                                                    // see RULE14
    else if (m == MASTER_MCU)
      allowed = 1'b1;                                                    // see RULE3
    else if (m == MASTER_MGR)
      allowed = (r != REGION_REGS) || is_ep0_reg(a);                     // see RULE3
    else if (m == MASTER_DMA) begin
      if (r == REGION_REGS)
        allowed = is_ep0_reg(a) || a == UART_RX_DATA || a == UART_TX_DATA; // see RULE4
      else if (r == REGION_DESC)
        allowed = upd;                                                   // see RULE4
      else
        allowed = r != REGION_SETUP;                                     // see RULE6
    end
  endfunction

  // arbitration: a master is not picked again in the cycle its grant shows
  logic    mcu_elig;
  logic    mgr_elig;
  logic    dma_elig;
  master_t pick;
  logic    take;
  logic    sel_we;
  logic [15:0] sel_addr;
  logic [7:0]  sel_wdata;
  region_t sel_region;
  logic    ok;

  assign mcu_elig = mcu_req && !mcu_grant_reg;
  assign mgr_elig = usb_buffer_manager_req && !usb_buffer_manager_grant_reg;
  assign dma_elig = dma_req && !dma_grant_reg;

  always_comb begin
    pick      = MASTER_NONE;
    sel_we    = 1'b0;
    sel_addr  = 16'h0000;
    sel_wdata = 8'h00;
    if (mcu_elig) begin                                                  // see RULE15
      pick      = MASTER_MCU;
      sel_we    = mcu_we;
      sel_addr  = mcu_addr;
      sel_wdata = mcu_wdata;
    end else if (mgr_elig) begin
      pick      = MASTER_MGR;
      sel_we    = usb_buffer_manager_we;
      sel_addr  = usb_buffer_manager_addr;
      sel_wdata = usb_buffer_manager_wdata;
    end else if (dma_elig) begin
      pick      = MASTER_DMA;
      sel_we    = dma_we;
      sel_addr  = dma_addr;
      sel_wdata = dma_wdata;
    end
  end

  assign take       = pick != MASTER_NONE;
  assign sel_region = region_of(sel_addr);
  assign ok         = take && allowed(pick, sel_region, sel_addr, dma_desc_update);

  // grant pulses
  always_ff @(posedge clk) begin
    if (reset) begin
      mcu_grant_reg                <= 1'b0;
      usb_buffer_manager_grant_reg <= 1'b0;
      dma_grant_reg                <= 1'b0;
    end else begin
      mcu_grant_reg                <= pick == MASTER_MCU;                // see RULE15
      usb_buffer_manager_grant_reg <= pick == MASTER_MGR;
      dma_grant_reg                <= pick == MASTER_DMA;
    end
  end

  // target stage
  master_t s1_master_reg;
  logic    s1_read_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      tgt_valid_reg  <= 1'b0;
      tgt_we_reg     <= 1'b0;
      tgt_region_reg <= REGION_OUTSIDE;
      tgt_offset_reg <= '0;
      tgt_wdata_reg  <= 8'h00;
      refused_reg    <= 1'b0;
      s1_master_reg  <= MASTER_NONE;
      s1_read_reg    <= 1'b0;
    end else begin
      tgt_valid_reg  <= ok;
      tgt_we_reg     <= ok && sel_we;                                    // see RULE14
      tgt_region_reg <= sel_region;
      tgt_offset_reg <= sel_addr[OFFSET_WIDTH-1:0];
      tgt_wdata_reg  <= sel_wdata;
      refused_reg    <= take && !ok;                                     // see RULE14
      s1_master_reg  <= pick;
      s1_read_reg    <= ok && !sel_we;
    end
  end

  // completion stage
  always_ff @(posedge clk) begin
    if (reset) begin
      done_reg  <= 3'b000;
      rdata_reg <= 8'h00;
    end else begin
      done_reg  <= 3'b000;
      if (s1_master_reg != MASTER_NONE)
        done_reg[s1_master_reg] <= 1'b1;
      rdata_reg <= s1_read_reg ? tgt_rdata : READ_ZERO;                  // see RULE14
    end
  end

  // checks
  sequence s_refused_take;
    take && !ok;
  endsequence
  sequence s_zero_answer;
    refused_reg && !tgt_valid_reg && !tgt_we_reg ##1 rdata_reg == READ_ZERO;
  endsequence

  refuse_zero_a: assert property (@(posedge clk) disable iff (reset) // see RULE14
    s_refused_take |=> s_zero_answer) else $error("refused access not answered with zero");
  data_region_a: assert property (@(posedge clk) disable iff (reset) // see RULE7
    take && sel_addr >= BUFFER_SPACE_BASE && sel_addr <= BUFFER_SPACE_TOP
    |=> tgt_valid_reg && tgt_region_reg == REGION_DATA) else $error("data buffer misdecoded");
  reg_top_a: assert property (@(posedge clk) disable iff (reset) // see RULE2
    tgt_valid_reg && tgt_offset_reg >= MAPPED_SPACE_BASE[OFFSET_WIDTH-1:0]
    |-> tgt_region_reg == REGION_REGS)
    else $error("top 128 bytes reached non-register target");
  mgr_regs_a: assert property (@(posedge clk) disable iff (reset) // see RULE3
    tgt_valid_reg && s1_master_reg == MASTER_MGR && tgt_region_reg == REGION_REGS
    |-> tgt_offset_reg <= OUT_EP0_BYTE_COUNT[OFFSET_WIDTH-1:0])
    else $error("manager reached a non-ep0 register");
  setup_dma_a: assert property (@(posedge clk) disable iff (reset) // see RULE6
    take && pick == MASTER_DMA && sel_region == REGION_SETUP |=> refused_reg)
    else $error("dma reached setup store");
  desc_update_a: assert property (@(posedge clk) disable iff (reset) // see RULE4
    take && pick == MASTER_DMA && sel_region == REGION_DESC && !dma_desc_update
    |=> refused_reg ##1 done_reg == 3'b100) else $error("dma descriptor access not refused");
  mcu_all_a: assert property (@(posedge clk) disable iff (reset) // see RULE3
    take && pick == MASTER_MCU && sel_region != REGION_HOLE && sel_region != REGION_OUTSIDE
    |=> tgt_valid_reg && mcu_grant_reg) else $error("core access refused");
  priority_a: assert property (@(posedge clk) disable iff (reset) // see RULE15
    mcu_elig && mgr_elig |=> mcu_grant_reg && !usb_buffer_manager_grant_reg
    ##1 usb_buffer_manager_grant_reg || !usb_buffer_manager_req) else $error("priority broken");
  read_return_a: assert property (@(posedge clk) disable iff (reset) // see RULE1
    ok && !sel_we |=> !tgt_we_reg ##1 rdata_reg == $past(tgt_rdata))
    else $error("read data not returned");
  ep0_regs_a: assert property (@(posedge clk) disable iff (reset) // see RULE5
    take && pick == MASTER_MGR && sel_addr == OUT_EP0_BYTE_COUNT
    |=> tgt_valid_reg && tgt_region_reg == REGION_REGS) else $error("ep0 count not open");

  // access, decode and arbitration checks
  grant_onehot_a: assert property (@(posedge clk) disable iff (reset) // see RULE15
    $onehot0({dma_grant_reg, usb_buffer_manager_grant_reg, mcu_grant_reg}))
    else $error("more than one grant at once");
  done_follow_a: assert property (@(posedge clk) disable iff (reset) // see RULE15
    mcu_grant_reg || usb_buffer_manager_grant_reg || dma_grant_reg
    |=> done_reg == $past({dma_grant_reg, usb_buffer_manager_grant_reg, mcu_grant_reg}))
    else $error("completion does not follow grant");
  we_valid_a: assert property (@(posedge clk) disable iff (reset) // see RULE14
    tgt_we_reg |-> tgt_valid_reg && !refused_reg) else $error("write strobe without select");
  write_zero_a: assert property (@(posedge clk) disable iff (reset) // see RULE14
    ok && sel_we |=> tgt_we_reg ##1 rdata_reg == READ_ZERO) else $error("write returned data");
  hole_refused_a: assert property (@(posedge clk) disable iff (reset) // see RULE1
    take && sel_region == REGION_HOLE |=> refused_reg && tgt_region_reg == REGION_HOLE)
    else $error("hole access not refused");
  outside_refused_a: assert property (@(posedge clk) disable iff (reset) // see RULE1
    take && sel_addr < BUFFER_SPACE_BASE
    |=> refused_reg && tgt_region_reg == REGION_OUTSIDE)
    else $error("access below the window not refused");
  reg_range_a: assert property (@(posedge clk) disable iff (reset) // see RULE2
    take && sel_addr >= MAPPED_SPACE_BASE
    |=> tgt_region_reg == REGION_REGS || tgt_region_reg == REGION_HOLE)
    else $error("register range reached buffer storage");
  setup_map_a: assert property (@(posedge clk) disable iff (reset) // see RULE6
    take && sel_addr >= SETUP_BASE && sel_addr <= SETUP_TOP
    |=> tgt_region_reg == REGION_SETUP)
    else $error("setup store misdecoded");
  ep0_buffers_a: assert property (@(posedge clk) disable iff (reset) // see RULE7
    take && sel_addr >= OUT_EP0_BUF_BASE && sel_addr < SETUP_BASE
    |=> tgt_valid_reg && (tgt_region_reg == REGION_OUT_EP0 || tgt_region_reg == REGION_IN_EP0))
    else $error("ep0 buffer misdecoded");
  desc_map_a: assert property (@(posedge clk) disable iff (reset) // see RULE8
    take && pick != MASTER_DMA && (sel_addr >= OUT_EP1_DESC_CONFIG && sel_addr <= OUT_DESC_TOP
      || sel_addr >= IN_EP1_DESC_CONFIG && sel_addr <= IN_DESC_TOP)
    |=> tgt_valid_reg && tgt_region_reg == REGION_DESC) else $error("descriptor misdecoded");
  dma_reg_refused_a: assert property (@(posedge clk) disable iff (reset) // see RULE4
    take && pick == MASTER_DMA && sel_region == REGION_REGS && !is_ep0_reg(sel_addr)
      && sel_addr != UART_RX_DATA && sel_addr != UART_TX_DATA
    |=> refused_reg && !tgt_valid_reg) else $error("dma reached a closed register");
  mgr_reg_refused_a: assert property (@(posedge clk) disable iff (reset) // see RULE3
    take && pick == MASTER_MGR && sel_region == REGION_REGS && !is_ep0_reg(sel_addr)
    |=> refused_reg && !tgt_valid_reg) else $error("manager reached a closed register");

  // register map checks, from core decode to register select
  sequence s_reg_select;
    tgt_valid_reg && !refused_reg && tgt_region_reg == REGION_REGS;
  endsequence
  sequence s_core_usb_regs;
    take && pick == MASTER_MCU && sel_addr >= USB_CONTROL;
  endsequence
  sequence s_core_serial_number;
    take && pick == MASTER_MCU && sel_addr >= SERIAL_NUMBER_BYTE0
      && sel_addr <= SERIAL_NUMBER_BYTE7;
  endsequence
  sequence s_core_dma_regs;
    take && pick == MASTER_MCU && (sel_addr == DMA1_CHANNEL_DEFINITION
      || sel_addr == DMA1_CTRL_STATUS || sel_addr == DMA3_CHANNEL_DEFINITION
      || sel_addr == DMA3_CTRL_STATUS);
  endsequence
  sequence s_core_uart_regs;
    take && pick == MASTER_MCU && sel_addr >= UART_RX_DATA && sel_addr <= UART_INT_MASK;
  endsequence
  sequence s_core_system_regs;
    take && pick == MASTER_MCU && (sel_addr == WATCHDOG_CTRL_STATUS
      || sel_addr == INTERRUPT_VECTOR || sel_addr == CODE_SHADOW_CONFIG);
  endsequence

  usb_regs_a: assert property (@(posedge clk) disable iff (reset) // see RULE9
    s_core_usb_regs |=> s_reg_select) else $error("usb register not selected");
  serial_number_a: assert property (@(posedge clk) disable iff (reset) // see RULE10
    s_core_serial_number |=> s_reg_select) else $error("serial number byte not selected");
  dma_regs_a: assert property (@(posedge clk) disable iff (reset) // see RULE11
    s_core_dma_regs |=> s_reg_select) else $error("dma register not selected");
  uart_regs_a: assert property (@(posedge clk) disable iff (reset) // see RULE12
    s_core_uart_regs |=> s_reg_select) else $error("serial-port register not selected");
  system_regs_a: assert property (@(posedge clk) disable iff (reset) // see RULE13
    s_core_system_regs |=> s_reg_select) else $error("system register not selected");

endmodule // buffer_io_space_decoder

// ===== space_decoder_pkg.sv
// space_decoder_pkg: address map, region and master codes for the buffer/io space decoder
// assumes byte-wide data and a 16-bit data-space address shared by all masters
package space_decoder_pkg;
  // buffer and io window
  localparam logic [15:0] BUFFER_SPACE_BASE    = 16'hF800;
  localparam logic [15:0] BUFFER_SPACE_TOP     = 16'hFEEF;
  localparam logic [15:0] OUT_EP0_BUF_BASE     = 16'hFEF0;
  localparam logic [15:0] IN_EP0_BUF_BASE      = 16'hFEF8;
  localparam logic [15:0] SETUP_BASE           = 16'hFF00;
  localparam logic [15:0] SETUP_TOP            = 16'hFF07;
  localparam logic [15:0] OUT_EP1_DESC_CONFIG  = 16'hFF08;
  localparam logic [15:0] OUT_DESC_TOP         = 16'hFF1F;
  localparam logic [15:0] IN_EP1_DESC_CONFIG   = 16'hFF48;
  localparam logic [15:0] IN_DESC_TOP          = 16'hFF5F;
  localparam logic [15:0] MAPPED_SPACE_BASE    = 16'hFF80;
  // mapped registers
  localparam logic [15:0] IN_EP0_CONFIG        = 16'hFF80;
  localparam logic [15:0] OUT_EP0_BYTE_COUNT   = 16'hFF83;
  localparam logic [15:0] CODE_SHADOW_CONFIG   = 16'hFF90;
  localparam logic [15:0] INTERRUPT_VECTOR     = 16'hFF92;
  localparam logic [15:0] WATCHDOG_CTRL_STATUS = 16'hFF93;
  localparam logic [15:0] GPIO_PULLUP_PORT3    = 16'hFF9E;
  localparam logic [15:0] UART_RX_DATA         = 16'hFFA0;
  localparam logic [15:0] UART_TX_DATA         = 16'hFFA1;
  localparam logic [15:0] UART_INT_MASK        = 16'hFFAB;
  localparam logic [15:0] DMA1_CHANNEL_DEFINITION = 16'hFFE0;
  localparam logic [15:0] DMA1_CTRL_STATUS     = 16'hFFE1;
  localparam logic [15:0] DMA3_CHANNEL_DEFINITION = 16'hFFE4;
  localparam logic [15:0] DMA3_CTRL_STATUS     = 16'hFFE5;
  localparam logic [15:0] SERIAL_NUMBER_BYTE0  = 16'hFFE8;
  localparam logic [15:0] SERIAL_NUMBER_BYTE7  = 16'hFFEF;
  localparam logic [15:0] I2C_STATUS           = 16'hFFF0;
  localparam logic [15:0] I2C_ADDRESS          = 16'hFFF3;
  localparam logic [15:0] DEVICE_REV_LOW       = 16'hFFF5;
  localparam logic [15:0] USB_CONTROL          = 16'hFFFC;
  localparam logic [15:0] USB_INT_MASK         = 16'hFFFD;
  localparam logic [15:0] USB_STATUS           = 16'hFFFE;
  localparam logic [15:0] USB_FUNCTION_ADDRESS = 16'hFFFF;
  localparam int          OFFSET_WIDTH         = 11;
  localparam logic [7:0]  READ_ZERO            = 8'h00;

  typedef enum logic [2:0] {
    REGION_OUTSIDE = 3'b000,
    REGION_DATA    = 3'b001,
    REGION_OUT_EP0 = 3'b010,
    REGION_IN_EP0  = 3'b011,
    REGION_SETUP   = 3'b100,
    REGION_DESC    = 3'b101,
    REGION_REGS    = 3'b110,
    REGION_HOLE    = 3'b111
  } region_t;

  typedef enum logic [1:0] {
    MASTER_MCU = 2'b00,
    MASTER_MGR = 2'b01,
    MASTER_DMA = 2'b10,
    MASTER_NONE = 2'b11
  } master_t;
endpackage

// ===== target_model.sv
// target_model: byte store behind the decoder's target side
// assumes reads are answered combinationally while tgt_valid_reg stands
module target_model
  import space_decoder_pkg::*;
(
  // clock
  input  wire logic                    clk,
  // target side
  input  wire logic                    tgt_valid_reg,
  input  wire logic                    tgt_we_reg,
  input  wire logic [OFFSET_WIDTH-1:0] tgt_offset_reg,
  input  wire logic [7:0]              tgt_wdata_reg,
  output logic      [7:0]              tgt_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [2048];
  logic [7:0] idle_reg;
  initial begin
    idle_reg = 8'hC3;
    for (int i = 0; i < 2048; i++) mem[i] = 8'(i) ^ 8'h5A;
  end
  // idle read lines toggle so a stale value never passes for data
  always @(posedge clk) begin
    if (tgt_valid_reg && tgt_we_reg) mem[tgt_offset_reg] <= tgt_wdata_reg;
    idle_reg <= ~tgt_rdata;
  end
  assign tgt_rdata = tgt_valid_reg ? mem[tgt_offset_reg] : idle_reg;
endmodule // target_model

// ===== tb_top.sv
// tb_top: self-checking bench for the buffer/io space decoder
// assumes target_model answers target reads and starts with offset ^ 5A
module tb_top
  import space_decoder_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, reset, upd;
  logic [2:0] req, we;
  logic [15:0] addr [3];
  logic [7:0] wd [3];
  logic mg, ug, dg, tv, tw, rf;
  region_t rg;
  logic [10:0] tofs;
  logic [7:0] twd, trd, rd, shadow [2048];
  logic [2:0] dn;
  wire logic [2:0] gnt = {dg, ug, mg};
  int fails, num_checks;
  logic [15:0] tbl [44] = '{16'hF800, 16'hFEEF, 16'hFEF0, 16'hFEF7, 16'hFEF8, 16'hFEFF,
    16'hFF00, 16'hFF07, 16'hFF08, 16'hFF18, 16'hFF1F, 16'hFF20, 16'hFF47, 16'hFF48,
    16'hFF58, 16'hFF5F, 16'hFF60, 16'hFF80, 16'hFF81, 16'hFF82, 16'hFF83, 16'hFF84,
    16'hFF90, 16'hFF91, 16'hFF92, 16'hFF93, 16'hFF9E, 16'hFFA0, 16'hFFA1, 16'hFFAB,
    16'hFFAC, 16'hFFE0, 16'hFFE1, 16'hFFE2, 16'hFFE4, 16'hFFE5, 16'hFFE8, 16'hFFEF,
    16'hFFF4, 16'hFFFC, 16'hFFFD, 16'hFFFE, 16'hFFFF, 16'hF7FF};
  buffer_io_space_decoder u_buffer_io_space_decoder (.clk(clk), .reset(reset),
    .mcu_req(req[0]), .mcu_we(we[0]), .mcu_addr(addr[0]), .mcu_wdata(wd[0]),
    .mcu_grant_reg(mg), .usb_buffer_manager_req(req[1]), .usb_buffer_manager_we(we[1]),
    .usb_buffer_manager_addr(addr[1]), .usb_buffer_manager_wdata(wd[1]),
    .usb_buffer_manager_grant_reg(ug), .dma_req(req[2]), .dma_we(we[2]), .dma_addr(addr[2]),
    .dma_wdata(wd[2]), .dma_desc_update(upd), .dma_grant_reg(dg), .tgt_valid_reg(tv),
    .tgt_we_reg(tw), .tgt_region_reg(rg), .tgt_offset_reg(tofs), .tgt_wdata_reg(twd),
    .tgt_rdata(trd), .refused_reg(rf), .done_reg(dn), .rdata_reg(rd));
  target_model u_target_model (.clk(clk), .tgt_valid_reg(tv), .tgt_we_reg(tw),
    .tgt_offset_reg(tofs), .tgt_wdata_reg(twd), .tgt_rdata(trd));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic mapped(logic [15:0] a);
    return a <= 16'hFF83 || a == 16'hFF90 || a == 16'hFF92 || a == 16'hFF93 ||
      a == 16'hFF9E || (a >= 16'hFFA0 && a <= 16'hFFAB) || a == 16'hFFE0 || a == 16'hFFE1 ||
      a == 16'hFFE4 || a == 16'hFFE5 || (a >= 16'hFFE8 && a <= 16'hFFF3) || a >= 16'hFFF5;
  endfunction
  function automatic region_t region_of(logic [15:0] a);
    if (a < 16'hF800) return REGION_OUTSIDE;
    if (a <= 16'hFEEF) return REGION_DATA;
    if (a <= 16'hFEF7) return REGION_OUT_EP0;
    if (a <= 16'hFEFF) return REGION_IN_EP0;
    if (a <= 16'hFF07) return REGION_SETUP;
    if (a <= 16'hFF1F || (a >= 16'hFF48 && a <= 16'hFF5F)) return REGION_DESC;
    if (a >= 16'hFF80 && mapped(a)) return REGION_REGS;
    return REGION_HOLE;
  endfunction
  function automatic logic allowed(int m, logic [15:0] a, logic u);
    region_t r;
    r = region_of(a);
    if (r == REGION_OUTSIDE || r == REGION_HOLE) return 1'b0;
    if (m == 0) return 1'b1;
    if (r == REGION_REGS) return a <= 16'hFF83 || (m == 2 && a <= 16'hFFA1 && a >= 16'hFFA0);
    if (m == 2 && r == REGION_SETUP) return 1'b0;
    if (m == 2 && r == REGION_DESC) return u;
    return 1'b1;
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic access(input int m, input logic w, input logic [15:0] a,
                        input logic [7:0] d, input logic u);
    int n;
    logic ok;
    logic [7:0] exp_rd;
    ok = allowed(m, a, u);
    addr[m] = a; wd[m] = d; we[m] = w; req[m] = 1'b1;
    if (m == 2) upd = u;
    n = 0;
    do begin
      @(posedge clk); #2; n++;
    end while (gnt[m] !== 1'b1 && n < 10);
    chk("grant", 16'(gnt), 16'h1 << m);
    chk("refused", 16'(rf), 16'(!ok));
    chk("valid", 16'(tv), 16'(ok));
    chk("tgt_we", 16'(tw), 16'(ok & w));
    chk("region", 16'(rg), 16'(region_of(a)));
    if (ok) chk("offset", 16'(tofs), 16'(a[10:0]));
    if (ok && w) chk("tgt_wdata", 16'(twd), 16'(d));
    exp_rd = (ok && !w) ? shadow[a[10:0]] : READ_ZERO;
    if (ok && w) shadow[a[10:0]] = d;
    req[m] = 1'b0;
    @(posedge clk); #2;
    chk("done", 16'(dn), 16'h1 << m);
    chk("rdata", 16'(rd), 16'(exp_rd));
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #(50 * 8000);
    fails++;
    complete_run();
  end
  initial begin
    reset = 1'b1; req = '0; we = '0; upd = 1'b0;
    for (int i = 0; i < 3; i++) begin addr[i] = 16'hF800; wd[i] = 8'h00; end
    for (int i = 0; i < 2048; i++) shadow[i] = 8'(i) ^ 8'h5A;
    void'($urandom(32'hF55D));
    repeat (20) @(posedge clk);
    #2;
    chk("reset_done", 16'(dn), 16'h0000);
    reset = 1'b0;
    for (int m = 0; m < 3; m++)
      foreach (tbl[i]) begin
        access(m, 1'b1, tbl[i], 8'($urandom), 1'($urandom));
        access(m, 1'b0, tbl[i], 8'h00, 1'($urandom));
      end
    $display("test map done");
    for (int i = 0; i < 3; i++) begin addr[i] = 16'hF900 + 16'(i); we[i] = 1'b0; end
    req = 3'b111;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk); #2;
      chk("grant_order", 16'(gnt), (k < 3) ? 16'h1 << k : 16'h0);
      chk("done_order", 16'(dn), (k > 0) ? 16'h1 << (k - 1) : 16'h0);
      if (k > 0) chk("rdata_order", 16'(rd), 16'(shadow[11'h100 + k - 1]));
      if (k < 3) req[k] = 1'b0;
    end
    $display("test priority done");
    repeat (300) access($urandom_range(2), 1'($urandom), 16'($urandom_range(16'hFFFF, 16'hF700)),
                         8'($urandom), 1'($urandom));
    $display("test random done");
    complete_run();
  end
endmodule // tb_top
